//--- src/ldio_pkg.sv
package ldio_pkg;

    // Host address width and the part compared against programmed bases
    localparam int unsigned ADDR_W      = 16;
    localparam int unsigned BASE_W      = 12;

    // Device numbers, alternate numbering
    localparam logic [7:0] ALT_FLOPPY   = 8'h00;
    localparam logic [7:0] ALT_SERIAL2  = 8'h02;
    localparam logic [7:0] ALT_PARALLEL = 8'h03;
    localparam logic [7:0] ALT_SERIAL1  = 8'h04;
    localparam logic [7:0] ALT_KEYBOARD = 8'h07;
    localparam logic [7:0] ALT_RUNTIME  = 8'h0a;

    // Device numbers, default numbering
    localparam logic [7:0] DEF_FLOPPY   = 8'h00;
    localparam logic [7:0] DEF_PARALLEL = 8'h01;
    localparam logic [7:0] DEF_SERIAL2  = 8'h02;
    localparam logic [7:0] DEF_SERIAL1  = 8'h03;
    localparam logic [7:0] DEF_POWER    = 8'h04;
    localparam logic [7:0] DEF_MOUSE    = 8'h05;
    localparam logic [7:0] DEF_KEYBOARD = 8'h06;
    localparam logic [7:0] DEF_GPIO     = 8'h07;
    localparam logic [7:0] NUM_NONE     = 8'hff;

    // Configuration port pair
    localparam logic [7:0]  CFG_IDX_BASE_LO = 8'h26;
    localparam logic [7:0]  CFG_IDX_BASE_HI = 8'h27;
    localparam logic [11:0] CFG_BASE_MIN    = 12'h100;
    localparam logic [11:0] CFG_BASE_MAX    = 12'hffe;
    localparam logic [11:0] CFG_BASE_RST    = 12'h12e; // Inside the relocation range: answers out of reset
    localparam logic [11:0] CFG_DATA_OFS    = 12'h001;

    // Relocatable window limits
    localparam logic [11:0] WIN8_MIN    = 12'h100;
    localparam logic [11:0] WIN8_MAX    = 12'hff8;
    localparam logic [11:0] WIN4_MAX    = 12'hffc;
    localparam logic [11:0] RT_MIN      = 12'h000;
    localparam logic [11:0] RT_MAX      = 12'hfc0;
    localparam logic [11:0] GRP32_MAX   = 12'hfe0;
    localparam logic [11:0] SIZE8_MASK  = 12'hff8;
    localparam logic [11:0] SIZE4_MASK  = 12'hffc;
    localparam logic [11:0] SIZE2_MASK  = 12'hffe;
    localparam logic [11:0] SIZE32_MASK = 12'hfe0;
    localparam logic [11:0] SIZE64_MASK = 12'hfc0;
    localparam logic [11:0] EPP_OFS_MIN = 12'h003;

    // Fixed keyboard ports
    localparam logic [11:0] KBD_DATA_PORT = 12'h060;
    localparam logic [11:0] KBD_CMD_PORT  = 12'h064;

    // Global oscillator configuration: 16-bit qualification bit
    localparam int unsigned OSC_QUAL16_BIT = 6;

    // Claim targets
    typedef enum logic [3:0] {
        LDIO_T_NONE, LDIO_T_CFG_INDEX, LDIO_T_CFG_DATA, LDIO_T_FLOPPY,
        LDIO_T_SERIAL1, LDIO_T_SERIAL2, LDIO_T_PARALLEL, LDIO_T_EPP,
        LDIO_T_KEYBOARD, LDIO_T_RUNTIME, LDIO_T_POWER, LDIO_T_GPIO, LDIO_T_MOUSE
    } ldio_target_e;

    // Programmed bases and enables of the relocatable devices
    typedef struct packed {
        logic [11:0] floppy;
        logic [11:0] serial1;
        logic [11:0] serial2;
        logic [11:0] parallel;
        logic [11:0] runtime;
        logic [11:0] gpio;
        logic [5:0]  enable;   // floppy,ser1,ser2,par,runtime/power,gpio
    } ldio_bases_s;

    // One host I/O cycle
    typedef struct packed {
        logic               valid;
        logic               write;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         wdata;
    } ldio_req_s;

    // Decode answer
    typedef struct packed {
        logic         claim;
        ldio_target_e target;
        logic [7:0]   dev_num;
        logic [11:0]  offset;
    } ldio_hit_s;

endpackage

//--- src/ldio_window.sv
`timescale 1ns/1ps
// Match one aligned window of the low address bits
module ldio_window
    import ldio_pkg::*;
#(
    parameter logic [11:0] SIZE_MASK = 12'hff8,
    parameter logic [11:0] MIN_BASE  = 12'h100,
    parameter logic [11:0] MAX_BASE  = 12'hff8
)(
    input  wire logic [11:0] addr,
    input  wire logic [11:0] base,
    input  wire logic        enable,
    output logic             hit,
    output logic [11:0]      offset
);
    logic base_ok;

    // A base off its boundary or outside its range decodes nothing
    assign base_ok = ((base & ~SIZE_MASK) == 12'h000) && (base >= MIN_BASE) && (base <= MAX_BASE);
    assign hit     = enable && base_ok && ((addr & SIZE_MASK) == base);
    assign offset  = addr & ~SIZE_MASK;
endmodule

//--- src/ldio_decoder.sv
`timescale 1ns/1ps
module ldio_decoder
    import ldio_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire ldio_req_s   req,
    input  wire ldio_bases_s bases,
    input  wire logic        device_numbering_select,
    input  wire logic [7:0]  global_oscillator_config,
    output ldio_hit_s        hit,
    output logic [7:0]       cfg_index,
    output logic [11:0]      cfg_base,
    output logic             cfg_write,
    output logic [7:0]       cfg_wdata,
    output logic             wake_event_status_sel
);
    logic [11:0]  a_lo;
    logic         upper_ok;
    logic         h_flp, h_s1, h_s2, h_p8, h_p4, h_rt, h_pw, h_gp, h_cfg;
    logic [11:0]  o_flp, o_s1, o_s2, o_p8, o_p4, o_rt, o_pw, o_gp, o_cfg;
    logic [7:0]   cfg_index_ff;
    logic [11:0]  cfg_base_ff;
    ldio_hit_s    nxt_hit;
    ldio_hit_s    hit_ff;
    logic         cfg_write_ff;
    logic [7:0]   cfg_wdata_ff;

    // Number of a target in the selected numbering scheme
    function automatic logic [7:0] dev_number(input ldio_target_e t, input logic alt);
        logic [7:0] n;
        n = NUM_NONE;
        case (t)
            LDIO_T_FLOPPY:   n = alt ? ALT_FLOPPY   : DEF_FLOPPY;
            LDIO_T_SERIAL1:  n = alt ? ALT_SERIAL1  : DEF_SERIAL1;
            LDIO_T_SERIAL2:  n = alt ? ALT_SERIAL2  : DEF_SERIAL2;
            LDIO_T_PARALLEL: n = alt ? ALT_PARALLEL : DEF_PARALLEL;
            LDIO_T_EPP:      n = alt ? ALT_PARALLEL : DEF_PARALLEL;
            LDIO_T_KEYBOARD: n = alt ? ALT_KEYBOARD : DEF_KEYBOARD;
            LDIO_T_RUNTIME:  n = ALT_RUNTIME;
            LDIO_T_POWER:    n = DEF_POWER;
            LDIO_T_GPIO:     n = DEF_GPIO;
            LDIO_T_MOUSE:    n = DEF_MOUSE;
            default:         n = NUM_NONE;
        endcase
        return n;
    endfunction

    assign a_lo = req.addr[BASE_W-1:0];
    // Upper bits only checked when 16-bit qualification is on
    assign upper_ok = !global_oscillator_config[OSC_QUAL16_BIT]
                      || (req.addr[ADDR_W-1:BASE_W] == 4'h0);

    // Eight-byte windows of floppy and serial ports
    ldio_window #(.SIZE_MASK(SIZE8_MASK), .MIN_BASE(WIN8_MIN), .MAX_BASE(WIN8_MAX)) u_flp (
        .addr(a_lo), .base(bases.floppy), .enable(bases.enable[5]), .hit(h_flp), .offset(o_flp)
    );
    ldio_window #(.SIZE_MASK(SIZE8_MASK), .MIN_BASE(WIN8_MIN), .MAX_BASE(WIN8_MAX)) u_s1 (
        .addr(a_lo), .base(bases.serial1), .enable(bases.enable[4]), .hit(h_s1), .offset(o_s1)
    );
    ldio_window #(.SIZE_MASK(SIZE8_MASK), .MIN_BASE(WIN8_MIN), .MAX_BASE(WIN8_MAX)) u_s2 (
        .addr(a_lo), .base(bases.serial2), .enable(bases.enable[3]), .hit(h_s2), .offset(o_s2)
    );

    // Parallel port: full eight-byte window, or four bytes when 4-aligned only
    ldio_window #(.SIZE_MASK(SIZE8_MASK), .MIN_BASE(WIN8_MIN), .MAX_BASE(WIN8_MAX)) u_p8 (
        .addr(a_lo), .base(bases.parallel), .enable(bases.enable[2]), .hit(h_p8), .offset(o_p8)
    );
    ldio_window #(.SIZE_MASK(SIZE4_MASK), .MIN_BASE(WIN8_MIN), .MAX_BASE(WIN4_MAX)) u_p4 (
        .addr(a_lo), .base(bases.parallel), .enable(bases.enable[2]), .hit(h_p4), .offset(o_p4)
    );

    // Runtime block (alternate) or power block (default) share the base
    ldio_window #(.SIZE_MASK(SIZE64_MASK), .MIN_BASE(RT_MIN), .MAX_BASE(RT_MAX)) u_rt (
        .addr(a_lo), .base(bases.runtime), .enable(bases.enable[1]), .hit(h_rt), .offset(o_rt)
    );
    ldio_window #(.SIZE_MASK(SIZE32_MASK), .MIN_BASE(RT_MIN), .MAX_BASE(GRP32_MAX)) u_pw (
        .addr(a_lo), .base(bases.runtime), .enable(bases.enable[1]), .hit(h_pw), .offset(o_pw)
    );
    ldio_window #(.SIZE_MASK(SIZE32_MASK), .MIN_BASE(RT_MIN), .MAX_BASE(GRP32_MAX)) u_gp (
        .addr(a_lo), .base(bases.gpio), .enable(bases.enable[0]), .hit(h_gp), .offset(o_gp)
    );

    // Configuration pair, always enabled
    ldio_window #(.SIZE_MASK(SIZE2_MASK), .MIN_BASE(CFG_BASE_MIN), .MAX_BASE(CFG_BASE_MAX)) u_cfg (
        .addr(a_lo), .base(cfg_base_ff), .enable(1'b1), .hit(h_cfg), .offset(o_cfg)
    );

    // Priority decode; config pair first, then the fixed keyboard ports
    always_comb
    begin
        nxt_hit        = '0;
        nxt_hit.target = LDIO_T_NONE;
        nxt_hit.dev_num = NUM_NONE;
        if (req.valid && upper_ok)
        begin
            if (h_cfg)
            begin
                nxt_hit.target = (o_cfg == CFG_DATA_OFS) ? LDIO_T_CFG_DATA
                                                         : LDIO_T_CFG_INDEX;
                nxt_hit.offset = o_cfg;
            end
            else if (a_lo == KBD_DATA_PORT || a_lo == KBD_CMD_PORT)
            begin
                nxt_hit.target = LDIO_T_KEYBOARD;
                nxt_hit.offset = a_lo - KBD_DATA_PORT;
            end
            else if (h_flp)
            begin
                nxt_hit.target = LDIO_T_FLOPPY;
                nxt_hit.offset = o_flp;
            end
            else if (h_s1)
            begin
                nxt_hit.target = LDIO_T_SERIAL1;
                nxt_hit.offset = o_s1;
            end
            else if (h_s2)
            begin
                nxt_hit.target = LDIO_T_SERIAL2;
                nxt_hit.offset = o_s2;
            end
            else if (h_p8)
            begin
                // EPP registers only exist on an eight-byte base
                nxt_hit.target = (o_p8 >= EPP_OFS_MIN) ? LDIO_T_EPP : LDIO_T_PARALLEL;
                nxt_hit.offset = o_p8;
            end
            else if (h_p4)
            begin
                nxt_hit.target = LDIO_T_PARALLEL;
                nxt_hit.offset = o_p4;
            end
            else if (device_numbering_select && h_rt)
            begin
                nxt_hit.target = LDIO_T_RUNTIME;
                nxt_hit.offset = o_rt;
            end
            else if (!device_numbering_select && h_pw)
            begin
                nxt_hit.target = LDIO_T_POWER;
                nxt_hit.offset = o_pw;
            end
            else if (!device_numbering_select && h_gp)
            begin
                nxt_hit.target = LDIO_T_GPIO;
                nxt_hit.offset = o_gp;
            end
            // Anything else stays unclaimed
            nxt_hit.claim   = (nxt_hit.target != LDIO_T_NONE);
            if (nxt_hit.claim)
                nxt_hit.dev_num = dev_number(nxt_hit.target, device_numbering_select);
        end
    end

    // Registered answer, one cycle after the request
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            hit_ff <= '0;
        else
            hit_ff <= nxt_hit;
    end

    // Index written only through a claimed index-port write
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cfg_index_ff <= 8'h00;
        else if (req.write && nxt_hit.target == LDIO_T_CFG_INDEX)
            cfg_index_ff <= req.wdata;
    end

    // Relocation of the pair; takes effect on the next cycle
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cfg_base_ff <= CFG_BASE_RST;
        else if (req.write && nxt_hit.target == LDIO_T_CFG_DATA)
        begin
            if (cfg_index_ff == CFG_IDX_BASE_LO)
                cfg_base_ff[7:0] <= req.wdata;
            else if (cfg_index_ff == CFG_IDX_BASE_HI)
                cfg_base_ff[11:8] <= req.wdata[3:0];
        end
    end

    // Data port write strobe toward the configuration registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_write_ff <= 1'b0;
            cfg_wdata_ff <= 8'h00;
        end
        else
        begin
            cfg_write_ff <= req.write && nxt_hit.target == LDIO_T_CFG_DATA;
            cfg_wdata_ff <= req.wdata;
        end
    end

    assign hit        = hit_ff;
    assign cfg_index  = cfg_index_ff;
    assign cfg_base   = cfg_base_ff;
    assign cfg_write  = cfg_write_ff;
    assign cfg_wdata  = cfg_wdata_ff;
    // Wake status is offset zero of the runtime block
    assign wake_event_status_sel = hit_ff.claim && hit_ff.target == LDIO_T_RUNTIME
                                   && hit_ff.offset == 12'h000;
endmodule

//--- sim/ldio_chk.sv
`timescale 1ns/1ps
// Port-level relations of the host address decoder
module ldio_chk
    import ldio_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire ldio_req_s   req,
    input wire ldio_bases_s bases,
    input wire logic        device_numbering_select,
    input wire logic [7:0]  global_oscillator_config,
    input wire ldio_hit_s   hit,
    input wire logic [7:0]  cfg_index,
    input wire logic [11:0] cfg_base,
    input wire logic        cfg_write,
    input wire logic [7:0]  cfg_wdata,
    input wire logic        wake_event_status_sel
);
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Request that passes the upper-bit qualification
    logic       qual;
    logic [2:0] low3;
    assign qual = req.valid && (!global_oscillator_config[OSC_QUAL16_BIT]
                  || req.addr[15:12] == 4'h0);
    assign low3 = req.addr[2:0];

    idle_no_claim_a: assert property (!req.valid |=> !hit.claim)
        else $error("claim without a request");
    upper_qual_a: assert property (req.valid && global_oscillator_config[6]
        && req.addr[15:12] != 4'h0 |=> !hit.claim) else $error("upper bits not qualified");
    unclaimed_num_a: assert property (!hit.claim && $past(reset_n)
        |-> hit.dev_num == NUM_NONE && hit.target == LDIO_T_NONE) else $error("stale number");
    kbd_fixed_a: assert property (qual && (req.addr[11:0] == KBD_DATA_PORT
        || req.addr[11:0] == KBD_CMD_PORT) |=> hit.claim && hit.target == LDIO_T_KEYBOARD
        && hit.dev_num == ($past(device_numbering_select) ? ALT_KEYBOARD : DEF_KEYBOARD))
        else $error("keyboard port missed");
    wake_sel_a: assert property (wake_event_status_sel
        == (hit.claim && hit.target == LDIO_T_RUNTIME && hit.offset == 12'h000))
        else $error("wake status select wrong");
    runtime_win_a: assert property (hit.target == LDIO_T_RUNTIME
        |-> hit.offset <= 12'h03f && hit.dev_num == ALT_RUNTIME && $past(device_numbering_select))
        else $error("runtime claim wrong");
    epp_ofs_a: assert property (hit.target == LDIO_T_EPP
        |-> hit.offset >= EPP_OFS_MIN && hit.offset <= 12'h007) else $error("epp offset wrong");
    win8_ofs_a: assert property (hit.target inside {LDIO_T_FLOPPY, LDIO_T_SERIAL1,
        LDIO_T_SERIAL2} |-> hit.offset <= 12'h007 && hit.offset[2:0] == $past(low3))
        else $error("eight byte window offset wrong");
    cfg_base_a: assert property ($changed(cfg_base) |-> cfg_write)
        else $error("pair base moved without data write");
    cfg_write_a: assert property (cfg_write |-> hit.target == LDIO_T_CFG_DATA)
        else $error("data write pulse without data port");
endmodule

//--- sim/ldio_host.sv
`timescale 1ns/1ps
// Host bus controller issuing one I/O cycle per clock
module ldio_host
    import ldio_pkg::*;
(
    input wire logic clock,
    output ldio_req_s req
);
    initial req = '0;

    // Cycle launched after an edge, taken at the next one
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    endtask

    // Released bus flips its lines so stale values never look like a cycle
    task automatic idle();
        @(posedge clock);
        req <= '{valid: 1'b0, write: ~req.write, addr: ~req.addr, wdata: ~req.wdata};
    endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import ldio_pkg::*;
();
    logic        clock, reset_n, sel, cfg_write, wake_sel, have_exp, e_w;
    logic [7:0]  osc, cfg_index, cfg_wdata, m_idx, e_wd;
    logic [11:0] cfg_base, a, m_base;
    ldio_req_s   req;
    ldio_bases_s bases;
    ldio_hit_s   hit, exp_h;
    int          error_cnt, n_compared, k;

    ldio_host ldio_host_i (.clock(clock), .req(req));
    ldio_decoder ldio_decoder_i (.clock(clock), .reset_n(reset_n), .req(req), .bases(bases),
        .device_numbering_select(sel), .global_oscillator_config(osc), .hit(hit),
        .cfg_index(cfg_index), .cfg_base(cfg_base), .cfg_write(cfg_write),
        .cfg_wdata(cfg_wdata), .wake_event_status_sel(wake_sel));

    function automatic bit inw(int a, int b, bit en, int sz, int lo, int hi);
        return en && b >= lo && b <= hi && b % sz == 0 && a >= b && a < b + sz;
    endfunction

    function automatic ldio_hit_s mk(ldio_target_e t, logic [7:0] n, int ofs);
        return '{claim: 1'b1, target: t, dev_num: n, offset: ofs[11:0]};
    endfunction

    // Reference decode; pair first, then the fixed keyboard ports
    function automatic ldio_hit_s model(ldio_req_s r, ldio_bases_s b, logic s, logic [7:0] o,
                                        logic [11:0] c);
        int x;
        x = int'(r.addr[11:0]);
        if (!r.valid || (o[6] && r.addr[15:12] != 4'h0))
            return '{1'b0, LDIO_T_NONE, 8'hff, 12'h000};
        if (inw(x, c, 1'b1, 2, 'h100, 'hffe))
            return mk(x == c ? LDIO_T_CFG_INDEX : LDIO_T_CFG_DATA, 8'hff, x - c);
        if (x == 'h60 || x == 'h64)
            return mk(LDIO_T_KEYBOARD, s ? 8'h07 : 8'h06, x - 'h60);
        if (inw(x, b.floppy, b.enable[5], 8, 'h100, 'hff8))
            return mk(LDIO_T_FLOPPY, 8'h00, x - b.floppy);
        if (inw(x, b.serial1, b.enable[4], 8, 'h100, 'hff8))
            return mk(LDIO_T_SERIAL1, s ? 8'h04 : 8'h03, x - b.serial1);
        if (inw(x, b.serial2, b.enable[3], 8, 'h100, 'hff8))
            return mk(LDIO_T_SERIAL2, 8'h02, x - b.serial2);
        if (inw(x, b.parallel, b.enable[2], 8, 'h100, 'hff8))
            return mk(x - b.parallel >= 3 ? LDIO_T_EPP : LDIO_T_PARALLEL,
                      s ? 8'h03 : 8'h01, x - b.parallel);
        if (inw(x, b.parallel, b.enable[2], 4, 'h100, 'hffc))
            return mk(LDIO_T_PARALLEL, s ? 8'h03 : 8'h01, x - b.parallel);
        if (s && inw(x, b.runtime, b.enable[1], 64, 0, 'hfc0))
            return mk(LDIO_T_RUNTIME, 8'h0a, x - b.runtime);
        if (!s && inw(x, b.runtime, b.enable[1], 32, 0, 'hfe0))
            return mk(LDIO_T_POWER, 8'h04, x - b.runtime);
        if (!s && inw(x, b.gpio, b.enable[0], 32, 0, 'hfe0))
            return mk(LDIO_T_GPIO, 8'h07, x - b.gpio);
        return '{1'b0, LDIO_T_NONE, 8'hff, 12'h000};
    endfunction

    function automatic logic [11:0] rnd(int sz);
        return 12'($urandom) & ~12'(sz - 1);
    endfunction

    task automatic chk_hit(ldio_hit_s g, logic gw, ldio_hit_s e);
        n_compared++;
        if (g.claim !== e.claim || g.target !== e.target || g.dev_num !== e.dev_num
            || g.offset !== e.offset
            || gw !== (e.claim && e.target == LDIO_T_RUNTIME && e.offset == 12'h000))
        begin
            error_cnt++;
            $display("wrong value at %0t: hit %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_cfg(logic [28:0] g, logic [28:0] e);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: pair state %h expected %h", $time, g, e);
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Answer lands one edge after the request is taken
    always @(posedge clock)
    begin
        if (have_exp && reset_n)
        begin
            chk_hit(hit, wake_sel, exp_h);
            chk_cfg({cfg_index, cfg_base, cfg_write, cfg_write ? cfg_wdata : 8'h00},
                    {m_idx, m_base, e_w, e_w ? e_wd : 8'h00});
        end
        // Pair state of the model follows the request just taken
        exp_h = model(req, bases, sel, osc, m_base);
        e_w = req.write && exp_h.target == LDIO_T_CFG_DATA;
        e_wd = req.wdata;
        if (req.write && exp_h.target == LDIO_T_CFG_INDEX)
            m_idx = req.wdata;
        if (e_w && m_idx == CFG_IDX_BASE_LO)
            m_base[7:0] = req.wdata;
        if (e_w && m_idx == CFG_IDX_BASE_HI)
            m_base[11:8] = req.wdata[3:0];
        if (!reset_n)
        begin
            m_idx = 8'h00;
            m_base = CFG_BASE_RST;
            e_w = 1'b0;
        end
        have_exp = reset_n;
    end

    initial
    begin
        #250000;
        error_cnt++;
        results();
    end

    initial
    begin
        reset_n = 1'b0;
        have_exp = 1'b0;
        bases = '0;
        sel = 1'b0;
        osc = 8'h00;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'h55fe8d06));
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        // Pair answers at its reset base; once moved, the old place goes quiet
        ldio_host_i.io(1'b1, {4'h0, CFG_BASE_RST}, CFG_IDX_BASE_LO);
        ldio_host_i.io(1'b1, {4'h0, CFG_BASE_RST + 12'h001}, 8'h40);
        ldio_host_i.io(1'b1, 16'h0140, CFG_IDX_BASE_HI);
        ldio_host_i.io(1'b1, 16'h0141, 8'h02);
        ldio_host_i.io(1'b0, 16'h0241, 8'h00);
        ldio_host_i.io(1'b1, {4'h0, CFG_BASE_RST}, 8'h5a);
        for (int p = 0; p < 16; p++)
        begin
            bases <= '{rnd(8), rnd(8), rnd(8), rnd(4), rnd(64), rnd(32),
                       6'($urandom) | (p[2] ? 6'h3f : 6'h00)};
            sel <= p[0];
            osc <= (8'($urandom) & 8'hbf) | {1'b0, p[1], 6'h00};
            repeat (150)
            begin
                k = $urandom % 9;
                case (k)
                    0: a = bases.floppy;
                    1: a = bases.serial1;
                    2: a = bases.serial2;
                    3: a = bases.parallel;
                    4: a = bases.runtime;
                    5: a = bases.gpio;
                    6: a = 12'h060 | 12'($urandom % 2) << 2;
                    7: a = m_base + 12'($urandom % 2);
                    default: a = 12'($urandom);
                endcase
                if (k < 6)
                    a = a + 12'($urandom % 72) - 12'h004;
                if ($urandom % 8 == 0)
                    ldio_host_i.idle();
                else
                    ldio_host_i.io(1'($urandom), {($urandom % 4 == 0) ? 4'($urandom) : 4'h0, a},
                                   8'($urandom));
            end
        end
        // Mid-run reset puts the pair back at its reset base
        ldio_host_i.idle();
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        ldio_host_i.io(1'b1, {4'h0, CFG_BASE_RST}, CFG_IDX_BASE_HI);
        ldio_host_i.io(1'b0, {4'h0, CFG_BASE_RST + 12'h001}, 8'h00);
        repeat (2) @(posedge clock);
        results();
    end
endmodule

bind ldio_decoder ldio_chk ldio_chk_i (.clock(clock), .reset_n(reset_n), .req(req),
    .bases(bases), .device_numbering_select(device_numbering_select),
    .global_oscillator_config(global_oscillator_config), .hit(hit), .cfg_index(cfg_index),
    .cfg_base(cfg_base), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
    .wake_event_status_sel(wake_event_status_sel));
